// [src/agcp_pkg.sv]
package agcp_pkg;

   // Register page and offsets
   localparam logic [7:0] AGCP_PAGE_CFG = 8'h00;
   localparam logic [7:0] AGCP_OFS_GAIN_CONTROL_CONFIG = 8'h70;
   localparam logic [7:0] AGCP_OFS_INPUT_CHANNEL_ENABLES = 8'h73;
   localparam logic [7:0] AGCP_OFS_OUTPUT_SLOT_ENABLES = 8'h74;
   localparam logic [7:0] AGCP_OFS_POWER_CONFIG = 8'h75;

   // Values after reset
   localparam logic [7:0] AGCP_RST_GAIN_CONTROL_CONFIG = 8'hE7;
   localparam logic [7:0] AGCP_RST_INPUT_CHANNEL_ENABLES = 8'hFC;
   localparam logic [7:0] AGCP_RST_OUTPUT_SLOT_ENABLES = 8'h00;
   localparam logic [7:0] AGCP_RST_POWER_CONFIG = 8'h00;

   // Writable bits; power bit 0 is read-only zero
   localparam logic [7:0] AGCP_WMASK_FULL = 8'hFF;
   localparam logic [7:0] AGCP_WMASK_POWER_CONFIG = 8'hFE;

   // Field positions
   localparam int AGCP_POS_TARGET_LEVEL_LSB = 4;
   localparam int AGCP_POS_CEILING_LSB = 0;
   localparam int AGCP_POS_CHAN_LSB = 2;
   localparam int AGCP_POS_BIAS_SUPPLY = 7;
   localparam int AGCP_POS_CONVERTER = 6;
   localparam int AGCP_POS_SYNTHESIZER = 5;
   localparam int AGCP_POS_LIVE_SWITCH = 4;
   localparam int AGCP_POS_SPAN_LSB = 2;

   // Gain decode, span code and channel count constants
   localparam logic [5:0] AGCP_TARGET_BASE_DB = 6'h06;
   localparam logic [3:0] AGCP_CEILING_MAX_CODE = 4'hD;
   localparam logic [1:0] AGCP_SPAN_TWO = 2'h0;
   localparam logic [1:0] AGCP_SPAN_FOUR = 2'h1;
   localparam int AGCP_CHANNELS = 6;

   typedef struct packed {
      logic [7:0] page;
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } agcp_req_type;

endpackage

// [src/agcp_reg8.sv]
`timescale 1ns/10ps
`default_nettype none

module agcp_reg8
   import agcp_pkg::*;
#(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WMASK = 8'hFF
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] q
);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= RESET_VAL;
      end else if (we) begin
         q <= (wdata & WMASK) | (q & ~WMASK);
      end
   end

endmodule

`default_nettype wire

// [src/agcp_regs.sv]
// What this block does
// - Gain config at 0x70, resets E7h
// - Target bits 7-4; codes 0-2 give -6..-10dB
// - Target codes 14, 15 give -34, -36dB
// - Ceiling bits 3-0; 3dB per code, 42dB top
// - Input enables at 0x73, reset FCh
// - Bits 7-2 enable channels one to six
// - Channels five, six only on six-channel variant
// - Slot enables at 0x74, reset zero
// - Bits 7-2 drive or tri-state slots
// - Slots five, six six-channel only; low bits reserved
// - Power config at 0x75, bit 0 read-only
// - Converter bit powers enabled channels, clear all
// - Bias and synthesizer power follow their bits
// - Live switching keeps channel one powered
// - Span picks the first two, four or six channels
`timescale 1ns/10ps
`default_nettype none

module agcp_regs
   import agcp_pkg::*;
#(
   parameter bit SIX_CHANNELS = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire agcp_req_type host_req,
   input wire logic recording_active,
   output logic [7:0] host_rdata,
   output logic host_rvalid,
   output logic [5:0] gain_target_level_db,
   output logic [5:0] gain_ceiling_db,
   output logic gain_ceiling_reserved,
   output logic [5:0] input_channel_enable_bit,
   output logic [5:0] output_slot_enable_bit,
   output logic bias_supply_power_on,
   output logic converter_power_on,
   output logic synthesizer_power_on,
   output logic [5:0] chan_power_on,
   output logic live_switch_violation
);

   logic [7:0] gain_q;
   logic [7:0] inen_q;
   logic [7:0] slot_q;
   logic [7:0] pwr_q;
   logic page_hit;
   logic we_gain;
   logic we_inen;
   logic we_slot;
   logic we_pwr;
   logic [7:0] rdata_nxt;
   logic [5:0] variant_mask;
   logic [5:0] inen_rev;
   logic [5:0] slot_rev;
   logic [3:0] target_code;
   logic [3:0] ceil_code;
   logic [5:0] ceil_plus1;
   logic [5:0] want;
   logic [5:0] span_mask;
   logic [5:0] chan_nxt;

   assign page_hit = (host_req.page == AGCP_PAGE_CFG);
   assign variant_mask = SIX_CHANNELS ? 6'h3F : 6'h0F;
   // Streams only as a plain source, never inside an expression
   assign inen_rev = {<<{inen_q[7:AGCP_POS_CHAN_LSB]}};
   assign slot_rev = {<<{slot_q[7:AGCP_POS_CHAN_LSB]}};

   // Unmapped offsets or other pages: writes dropped, reads zero
   always_comb begin
      we_gain = 1'b0;
      we_inen = 1'b0;
      we_slot = 1'b0;
      we_pwr = 1'b0;
      rdata_nxt = 8'h00;
      if (page_hit && host_req.addr == AGCP_OFS_GAIN_CONTROL_CONFIG) begin
         we_gain = host_req.wr;
         rdata_nxt = gain_q;
      end else if (page_hit && host_req.addr == AGCP_OFS_INPUT_CHANNEL_ENABLES) begin
         we_inen = host_req.wr;
         rdata_nxt = inen_q;
      end else if (page_hit && host_req.addr == AGCP_OFS_OUTPUT_SLOT_ENABLES) begin
         we_slot = host_req.wr;
         rdata_nxt = slot_q;
      end else if (page_hit && host_req.addr == AGCP_OFS_POWER_CONFIG) begin
         we_pwr = host_req.wr;
         rdata_nxt = pwr_q;
      end
   end

   agcp_reg8 #(.RESET_VAL(AGCP_RST_GAIN_CONTROL_CONFIG), .WMASK(AGCP_WMASK_FULL)) u_gain (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .we(we_gain),
      .wdata(host_req.wdata),
      .q(gain_q)
   );

   agcp_reg8 #(.RESET_VAL(AGCP_RST_INPUT_CHANNEL_ENABLES), .WMASK(AGCP_WMASK_FULL)) u_inen (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .we(we_inen),
      .wdata(host_req.wdata),
      .q(inen_q)
   );

   agcp_reg8 #(.RESET_VAL(AGCP_RST_OUTPUT_SLOT_ENABLES), .WMASK(AGCP_WMASK_FULL)) u_slot (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .we(we_slot),
      .wdata(host_req.wdata),
      .q(slot_q)
   );

   // power config, bit 0 not writable
   agcp_reg8 #(.RESET_VAL(AGCP_RST_POWER_CONFIG), .WMASK(AGCP_WMASK_POWER_CONFIG)) u_pwr (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .we(we_pwr),
      .wdata(host_req.wdata),
      .q(pwr_q)
   );

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         host_rdata <= 8'h00;
         host_rvalid <= 1'b0;
      end else begin
         host_rdata <= host_req.rd ? rdata_nxt : host_rdata;
         host_rvalid <= host_req.rd;
      end
   end

   // Gain decode
   assign target_code = gain_q[AGCP_POS_TARGET_LEVEL_LSB +: 4];
   // reserved ceiling codes clamp to the top gain rather than wrap
   assign ceil_code = (gain_q[AGCP_POS_CEILING_LSB +: 4] > AGCP_CEILING_MAX_CODE) ?
                      AGCP_CEILING_MAX_CODE : gain_q[AGCP_POS_CEILING_LSB +: 4];
   assign ceil_plus1 = {2'b00, ceil_code} + 6'h01;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         gain_target_level_db <= 6'h00;
         gain_ceiling_db <= 6'h00;
         gain_ceiling_reserved <= 1'b0;
      end else begin
         gain_target_level_db <= AGCP_TARGET_BASE_DB + {1'b0, target_code, 1'b0};
         gain_ceiling_db <= ceil_plus1 + {ceil_plus1[4:0], 1'b0};
         gain_ceiling_reserved <= (gain_q[AGCP_POS_CEILING_LSB +: 4] > AGCP_CEILING_MAX_CODE);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         input_channel_enable_bit <= 6'h00;
         output_slot_enable_bit <= 6'h00;
         bias_supply_power_on <= 1'b0;
         converter_power_on <= 1'b0;
         synthesizer_power_on <= 1'b0;
      end else begin
         // msb is channel one, reversed to index 0
         input_channel_enable_bit <= inen_rev & variant_mask;
         output_slot_enable_bit <= slot_rev & variant_mask;
         bias_supply_power_on <= pwr_q[AGCP_POS_BIAS_SUPPLY];
         synthesizer_power_on <= pwr_q[AGCP_POS_SYNTHESIZER];
         converter_power_on <= pwr_q[AGCP_POS_CONVERTER];
      end
   end

   // span; undefined code 3 treated as all six
   always_comb begin
      if (pwr_q[AGCP_POS_SPAN_LSB +: 2] == AGCP_SPAN_TWO) begin
         span_mask = 6'h03;
      end else if (pwr_q[AGCP_POS_SPAN_LSB +: 2] == AGCP_SPAN_FOUR) begin
         span_mask = 6'h0F;
      end else begin
         span_mask = 6'h3F;
      end
   end

   // converter bit gates the enabled channels
   assign want = pwr_q[AGCP_POS_CONVERTER] ? (inen_rev & variant_mask) : 6'h00;

   // Outside recording channels follow at once; inside, with the converter bit set, they freeze unless live switching
   always_comb begin
      chan_nxt = want;
      if (recording_active && pwr_q[AGCP_POS_CONVERTER]) begin
         if (pwr_q[AGCP_POS_LIVE_SWITCH]) begin
            chan_nxt = (want & span_mask) | (chan_power_on & ~span_mask);
            // channel one is held on while live switching
            chan_nxt[0] = chan_power_on[0] | want[0];
         end else begin
            chan_nxt = chan_power_on;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         chan_power_on <= 6'h00;
         live_switch_violation <= 1'b0;
      end else begin
         chan_power_on <= chan_nxt;
         live_switch_violation <= recording_active && pwr_q[AGCP_POS_CONVERTER] &&
                                  pwr_q[AGCP_POS_LIVE_SWITCH] && chan_power_on[0] && !want[0];
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_write_inen;
      host_req.wr && page_hit && host_req.addr == AGCP_OFS_INPUT_CHANNEL_ENABLES;
   endsequence

   sequence s_read_inen;
      host_req.rd && !host_req.wr && page_hit && host_req.addr == AGCP_OFS_INPUT_CHANNEL_ENABLES;
   endsequence

   a_gain_readback: assert property (
      (host_req.rd && page_hit && host_req.addr == AGCP_OFS_GAIN_CONTROL_CONFIG)
      |=> host_rvalid && host_rdata == $past(gain_q))
      else $error("gain config readback wrong");

   a_target_decode: assert property (
      rst_b |=> gain_target_level_db == 6'(6'h06 + 6'($past(gain_q[7:4])) * 6'h02))
      else $error("target level decode wrong");

   a_ceiling_decode: assert property (
      ($past(rst_b) && $past(gain_q[3:0]) <= 4'hD) |-> gain_ceiling_db == 6'((6'($past(gain_q[3:0])) + 6'h01) * 6'h03))
      else $error("ceiling decode wrong");

   a_inen_write_read: assert property (
      s_write_inen ##1 s_read_inen |=> host_rdata == $past(host_req.wdata, 2))
      else $error("input enable write then read mismatch");

   a_variant_masks: assert property (
      !SIX_CHANNELS |-> input_channel_enable_bit[5:4] == 2'b00 && output_slot_enable_bit[5:4] == 2'b00)
      else $error("variant channels five six active");

   a_slot_order: assert property (
      ##1 output_slot_enable_bit[0] == $past(slot_q[7]) && output_slot_enable_bit[3] == $past(slot_q[4]))
      else $error("slot enable order wrong");

   a_pwr_bit0_ro: assert property (
      pwr_q[0] == 1'b0)
      else $error("power config bit 0 written");

   a_converter_off: assert property (
      !pwr_q[AGCP_POS_CONVERTER] |=> chan_power_on == 6'h00)
      else $error("channels stay on with converter off");

   a_supplies_follow: assert property (
      ##1 bias_supply_power_on == $past(pwr_q[7]) && synthesizer_power_on == $past(pwr_q[5]))
      else $error("supply control lags or wrong");

   a_ch1_held: assert property (
      (recording_active && pwr_q[6] && pwr_q[4] && chan_power_on[0]) |=> chan_power_on[0])
      else $error("channel one dropped while live switching");

   a_span_freeze: assert property (
      (recording_active && pwr_q[6] && pwr_q[4] && pwr_q[3:2] == 2'b00)
      |=> chan_power_on[5:2] == $past(chan_power_on[5:2]))
      else $error("channel outside span changed");

endmodule

`default_nettype wire

// [verif/agcp_host.sv]
`timescale 1ns/10ps
`default_nettype none

module agcp_host
   import agcp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [7:0] host_rdata,
   input wire logic host_rvalid,
   output var agcp_req_type host_req
);
   initial begin
      host_req = '0;
   end

   task automatic wr(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] data);
      logic [7:0] d;
      d = data;
      if (page == AGCP_PAGE_CFG && addr == AGCP_OFS_GAIN_CONTROL_CONFIG && d[3:0] > AGCP_CEILING_MAX_CODE) begin
         d[3:0] = AGCP_CEILING_MAX_CODE;
      end
      @(posedge ref_clk);
      host_req <= '{page: page, addr: addr, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge ref_clk);
      // Released lines show inverted data, not stale values
      host_req <= '{page: ~page, addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask

   task automatic rd(input logic [7:0] page, input logic [7:0] addr, output logic [7:0] data, output bit ok);
      ok = 1'b0;
      data = 8'h00;
      @(posedge ref_clk);
      host_req <= '{page: page, addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge ref_clk);
      host_req <= '{page: ~page, addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
      for (int n = 0; n < 4 && !ok; n++) begin
         #1;
         if (host_rvalid === 1'b1) begin
            ok = 1'b1;
            data = host_rdata;
         end else begin
            @(posedge ref_clk);
         end
      end
   endtask

   // Write then read the same register on the very next edge
   task automatic wr_rd(input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rdata, output bit ok);
      ok = 1'b0;
      rdata = 8'h00;
      @(posedge ref_clk);
      host_req <= '{page: AGCP_PAGE_CFG, addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
      @(posedge ref_clk);
      host_req <= '{page: AGCP_PAGE_CFG, addr: addr, wr: 1'b0, rd: 1'b1, wdata: data};
      @(posedge ref_clk);
      host_req <= '{page: ~AGCP_PAGE_CFG, addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~data};
      for (int n = 0; n < 4 && !ok; n++) begin
         #1;
         if (host_rvalid === 1'b1) begin
            ok = 1'b1;
            rdata = host_rdata;
         end else begin
            @(posedge ref_clk);
         end
      end
   endtask
endmodule

`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import agcp_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic recording_active = 1'b0;
   agcp_req_type host_req;
   logic [7:0] host_rdata;
   logic host_rvalid;
   logic [5:0] tgt_db, ceil_db, in_en, slot_en, chan_on;
   logic ceil_rsv, bias_on, conv_on, synth_on, live_viol;
   int err_total = 0;
   int check_count = 0;
   logic [7:0] mdl [logic [7:0]];
   logic [5:0] chan_m = 6'h00;
   logic viol_m = 1'b0;

   always #20 ref_clk = ~ref_clk;

   agcp_regs i_agcp_regs (.ref_clk(ref_clk), .rst_b(rst_b), .host_req(host_req),
      .recording_active(recording_active), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
      .gain_target_level_db(tgt_db), .gain_ceiling_db(ceil_db), .gain_ceiling_reserved(ceil_rsv),
      .input_channel_enable_bit(in_en), .output_slot_enable_bit(slot_en), .bias_supply_power_on(bias_on),
      .converter_power_on(conv_on), .synthesizer_power_on(synth_on), .chan_power_on(chan_on),
      .live_switch_violation(live_viol));

   agcp_host i_agcp_host (.ref_clk(ref_clk), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
      .host_req(host_req));

   task automatic results();
      if (err_total == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Register bit 7 is channel 1
   function automatic logic [5:0] rev6(input logic [7:0] v);
      for (int i = 0; i < 6; i++) begin
         rev6[i] = v[7 - i];
      end
   endfunction

   function automatic logic [5:0] cnext(input logic [5:0] cur);
      logic [7:0] p;
      logic [5:0] en;
      logic [5:0] m;
      p = mdl[AGCP_OFS_POWER_CONFIG];
      en = rev6(mdl[AGCP_OFS_INPUT_CHANNEL_ENABLES]);
      m = (p[3:2] == 2'd0) ? 6'h03 : (p[3:2] == 2'd1) ? 6'h0f : 6'h3f;
      if (!p[6]) begin
         return 6'h00;
      end
      if (!recording_active) begin
         return en;
      end
      if (!p[4]) begin
         return cur;
      end
      return (cur & ~m) | (en & m) | (cur & 6'h01);
   endfunction

   task automatic outs();
      logic [7:0] g;
      logic [7:0] p;
      g = mdl[AGCP_OFS_GAIN_CONTROL_CONFIG];
      p = mdl[AGCP_OFS_POWER_CONFIG];
      chk("target_db", 8'(6 + 2 * g[7:4]), {2'b00, tgt_db});
      chk("ceiling_db", 8'(3 * (g[3:0] + 1)), {2'b00, ceil_db});
      chk("input_en", {2'b00, rev6(mdl[AGCP_OFS_INPUT_CHANNEL_ENABLES])}, {2'b00, in_en});
      chk("slot_en", {2'b00, rev6(mdl[AGCP_OFS_OUTPUT_SLOT_ENABLES])}, {2'b00, slot_en});
      chk("power", {5'b00000, p[7:5]}, {5'b00000, bias_on, conv_on, synth_on});
      chk("chan_power", {2'b00, chan_m}, {2'b00, chan_on});
      chk("ceiling_rsv", {7'h00, g[3:0] > AGCP_CEILING_MAX_CODE}, {7'h00, ceil_rsv});
      chk("live_viol", {7'h00, viol_m}, {7'h00, live_viol});
   endtask

   task automatic settle();
      logic [7:0] p;
      p = mdl[AGCP_OFS_POWER_CONFIG];
      viol_m = recording_active && p[6] && p[4] && chan_m[0] && !mdl[AGCP_OFS_INPUT_CHANNEL_ENABLES][7];
      chan_m = cnext(chan_m);
      outs();
   endtask

   task automatic putget(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      bit ok;
      i_agcp_host.wr_rd(a, d, r, ok);
      mdl[a] = d;
      if (!ok) begin
         err_total++;
         $display("[FAIL] rvalid expected 1 seen 0");
         results();
      end
      chk("rdata_b2b", d, r);
      settle();
   endtask

   task automatic put(input logic [7:0] a, input logic [7:0] d);
      i_agcp_host.wr(AGCP_PAGE_CFG, a, d);
      mdl[a] = (a == AGCP_OFS_POWER_CONFIG) ? (d & AGCP_WMASK_POWER_CONFIG) : d;
      @(posedge ref_clk);
      #1;
      settle();
   endtask

   task automatic get(input logic [7:0] p, input logic [7:0] a);
      logic [7:0] d;
      bit ok;
      i_agcp_host.rd(p, a, d, ok);
      if (!ok) begin
         err_total++;
         $display("[FAIL] rvalid expected 1 seen 0");
         results();
      end
      chk("rdata", (p == AGCP_PAGE_CFG && mdl.exists(a)) ? mdl[a] : 8'h00, d);
   endtask

   initial begin
      logic [7:0] v;
      void'($urandom(32'hd3b0));
      mdl[AGCP_OFS_GAIN_CONTROL_CONFIG] = AGCP_RST_GAIN_CONTROL_CONFIG;
      mdl[AGCP_OFS_INPUT_CHANNEL_ENABLES] = AGCP_RST_INPUT_CHANNEL_ENABLES;
      mdl[AGCP_OFS_OUTPUT_SLOT_ENABLES] = AGCP_RST_OUTPUT_SLOT_ENABLES;
      mdl[AGCP_OFS_POWER_CONFIG] = AGCP_RST_POWER_CONFIG;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      #1;
      outs();
      foreach (mdl[a]) begin
         get(AGCP_PAGE_CFG, a);
      end
      get(AGCP_PAGE_CFG, 8'h71);
      get(8'h01, AGCP_OFS_GAIN_CONTROL_CONFIG);
      for (int i = 0; i < 16; i++) begin
         put(AGCP_OFS_GAIN_CONTROL_CONFIG, {i[3:0], 4'(i % 14)});
      end
      for (int i = 0; i < 6; i++) begin
         v = 8'($urandom);
         put(i[0] ? AGCP_OFS_OUTPUT_SLOT_ENABLES : AGCP_OFS_INPUT_CHANNEL_ENABLES, v);
         get(AGCP_PAGE_CFG, i[0] ? AGCP_OFS_OUTPUT_SLOT_ENABLES : AGCP_OFS_INPUT_CHANNEL_ENABLES);
      end
      putget(AGCP_OFS_INPUT_CHANNEL_ENABLES, 8'($urandom));
      put(AGCP_OFS_POWER_CONFIG, 8'hff);
      get(AGCP_PAGE_CFG, AGCP_OFS_POWER_CONFIG);
      put(AGCP_OFS_POWER_CONFIG, 8'h00);
      put(AGCP_OFS_INPUT_CHANNEL_ENABLES, 8'hfc);
      put(AGCP_OFS_POWER_CONFIG, 8'hd0);
      @(posedge ref_clk);
      recording_active <= 1'b1;
      put(AGCP_OFS_INPUT_CHANNEL_ENABLES, 8'h3c);
      put(AGCP_OFS_POWER_CONFIG, 8'hd4);
      put(AGCP_OFS_INPUT_CHANNEL_ENABLES, 8'ha0);
      put(AGCP_OFS_POWER_CONFIG, 8'hd8);
      put(AGCP_OFS_INPUT_CHANNEL_ENABLES, 8'h80);
      put(AGCP_OFS_POWER_CONFIG, 8'h00);
      results();
   end
endmodule

`default_nettype wire
